// ---- hw/dso_pkg.sv ----
// dso_pkg: constants, register map and carrier structs for the drive
// status output selector. assumes a 32-bit APB register bus.
package dso_pkg;

  // register byte offsets
  localparam logic [7:0] REG_RELAY_FUNC   = 8'h00;
  localparam logic [7:0] REG_TARGET_FREQ  = 8'h04;
  localparam logic [7:0] REG_METER_SRC    = 8'h08;
  localparam logic [7:0] REG_METER_GAIN   = 8'h0C;
  localparam logic [7:0] REG_TERM_COUNT   = 8'h10;
  localparam logic [7:0] REG_PRELIM_COUNT = 8'h14;
  localparam logic [7:0] REG_TC_FAULT_EN  = 8'h18;
  localparam logic [7:0] REG_BRAKE_REL    = 8'h1C;
  localparam logic [7:0] REG_BRAKE_ENG    = 8'h20;
  localparam logic [7:0] REG_STATUS       = 8'h24;
  localparam logic [7:0] REG_COUNT        = 8'h28;
  localparam logic [7:0] REG_CTRL         = 8'h2C;

  // reset values
  localparam logic [4:0]  RST_RELAY_FUNC   = 5'h08;
  localparam logic [15:0] RST_TARGET_FREQ  = 16'h0000;
  localparam logic        RST_METER_SRC    = 1'b0;
  localparam logic [7:0]  RST_METER_GAIN   = 8'h64;
  localparam logic [13:0] RST_TERM_COUNT   = 14'h0000;
  localparam logic [13:0] RST_PRELIM_COUNT = 14'h0000;
  localparam logic        RST_TC_FAULT_EN  = 1'b0;
  localparam logic [15:0] RST_BRAKE        = 16'h0000;

  // limits
  localparam logic [4:0]  MAX_RELAY_FUNC = 5'h16;
  localparam logic [15:0] MAX_FREQ       = 16'hEA60;
  localparam logic [13:0] MAX_COUNT      = 14'h270F;
  localparam logic [7:0]  MIN_GAIN       = 8'h01;
  localparam logic [7:0]  MAX_GAIN       = 8'hC8;
  localparam logic [7:0]  GAIN_UNITY     = 8'h64;
  // current meter: 250 % full scale, expressed as 5/2
  localparam int          CUR_FS_NUM     = 5;
  localparam int          CUR_FS_DEN     = 2;

  // status register bit positions
  localparam int ST_RELAY  = 0;
  localparam int ST_TERM   = 1;
  localparam int ST_PRELIM = 2;
  localparam int ST_BRAKE  = 3;
  localparam int ST_EXTF   = 4;

  typedef enum logic [4:0] {
    FN_NONE, FN_OPERATIONAL, FN_MASTER_FREQ, FN_ZERO_SPEED, FN_OVER_TORQUE,
    FN_BASEBLOCK, FN_UNDERVOLTAGE, FN_TERMINAL_OP, FN_FAULT, FN_TARGET_FREQ,
    FN_TERM_COUNT, FN_PRELIM_COUNT, FN_OV_STALL, FN_OC_STALL, FN_HEATSINK,
    FN_DC_BUS_HIGH, FN_FEEDBACK_BAD, FN_FORWARD, FN_REVERSE, FN_STANDBY,
    FN_COMM_WARN, FN_BRAKE, FN_READY
  } dso_func_e;

  // condition flags from the rest of the drive
  typedef struct packed {
    logic ready;
    logic run_cmd;
    logic stop_cmd;
    logic over_torque;
    logic output_inhibit;
    logic undervoltage_flag;
    logic terminal_source;
    logic fault_any;
    logic ov_stall;
    logic oc_stall;
    logic heatsink_warn;
    logic dc_bus_high;
    logic feedback_bad;
    logic forward_direction;
    logic reverse_direction;
    logic standby;
    logic comm_warn;
  } dso_flags_s;

  // frequencies in 0.01 Hz, current in 0.1 % of rated
  typedef struct packed {
    logic [15:0] out_freq;
    logic [15:0] cmd_freq;
    logic [15:0] set_freq;
    logic [15:0] min_freq;
    logic [15:0] max_freq;
    logic [15:0] out_current;
  } dso_meas_s;

endpackage

// ---- hw/dso_selector.sv ----
// dso_selector: relay function select, event counter and meter scaling
// assumes flags and measurements are synchronous to pclk and count
// pulses are already one-cycle pulses; apb slave with zero wait states.
//
// Overview of operation
// - relay code 0..22, default 8, 0 off
// - code 1 ready or run; 22 ready
// - code 2 output reached set frequency
// - code 3 command below minimum frequency
// - code 4 while over-torque present
// - code 5 while output inhibited
// - code 6 while undervoltage detected
// - code 7 command from external terminals
// - code 8 any drive fault present
// - code 9 programmable target frequency reached
// - codes 10/11 terminal/preliminary count reached
// - codes 12,13,15 stall and bus supervision
// - code 14 heatsink early warning
// - code 16 feedback signal abnormal
// - codes 17/18 forward/reverse direction command
// - code 19 while standby flag set
// - code 20 communication warning present
// - code 21 brake release/engage hysteresis
// - meter source: frequency or 250% current
// - meter gain 1..200%, default 100
// - counter counts input pulses, terminal 0..9999
// - preliminary flag set, cleared at terminal
// - optional external fault at terminal count
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module dso_selector #(
  parameter int METER_W = 12
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire dso_pkg::dso_flags_s   flags,
  input  wire dso_pkg::dso_meas_s    meas,
  input  wire logic                  count_pulse,
  output logic                       relay_drive,
  output logic                       external_fault,
  output logic      [METER_W-1:0]    analog_meter_output
);

  // narrower meters lose all resolution; wider ones overflow the scaler
  if (METER_W < 4 || METER_W > 16) begin : g_bad_meter_w
    $error("dso_selector: METER_W must be 4..16");
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic [4:0]  relay_function_code;
  logic [15:0] target_frequency_setting;
  logic        meter_source_select;
  logic [7:0]  meter_gain;
  logic [13:0] terminal_count_setting;
  logic [13:0] preliminary_count_setting;
  logic        tc_fault_enable;
  logic [15:0] brake_release_threshold;
  logic [15:0] brake_engage_threshold;

  logic        wr_en;
  logic        rd_en;
  logic        clr_req;
  // writes commit in the access phase; pready is not consulted
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;

  // out-of-range writes are ignored so settings stay legal
  function automatic logic addr_known(input logic [7:0] a);
    case (a)
      dso_pkg::REG_RELAY_FUNC, dso_pkg::REG_TARGET_FREQ,
      dso_pkg::REG_METER_SRC, dso_pkg::REG_METER_GAIN,
      dso_pkg::REG_TERM_COUNT, dso_pkg::REG_PRELIM_COUNT,
      dso_pkg::REG_TC_FAULT_EN, dso_pkg::REG_BRAKE_REL,
      dso_pkg::REG_BRAKE_ENG, dso_pkg::REG_STATUS,
      dso_pkg::REG_COUNT, dso_pkg::REG_CTRL: addr_known = 1'b1;
      default: addr_known = 1'b0;
    endcase
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay_function_code <= dso_pkg::RST_RELAY_FUNC;
    end else if (wr_en && paddr == dso_pkg::REG_RELAY_FUNC &&
                 pwdata[4:0] <= dso_pkg::MAX_RELAY_FUNC &&
                 pwdata[31:5] == 27'h0000000) begin
      relay_function_code <= pwdata[4:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_frequency_setting <= dso_pkg::RST_TARGET_FREQ;
      brake_release_threshold  <= dso_pkg::RST_BRAKE;
      brake_engage_threshold   <= dso_pkg::RST_BRAKE;
    end else if (wr_en && pwdata[15:0] <= dso_pkg::MAX_FREQ) begin
      if (paddr == dso_pkg::REG_TARGET_FREQ) begin
        target_frequency_setting <= pwdata[15:0];
      end
      if (paddr == dso_pkg::REG_BRAKE_REL) begin
        brake_release_threshold <= pwdata[15:0];
      end
      if (paddr == dso_pkg::REG_BRAKE_ENG) begin
        brake_engage_threshold <= pwdata[15:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meter_source_select <= dso_pkg::RST_METER_SRC;
      meter_gain          <= dso_pkg::RST_METER_GAIN;
      tc_fault_enable     <= dso_pkg::RST_TC_FAULT_EN;
    end else if (wr_en) begin
      if (paddr == dso_pkg::REG_METER_SRC) begin
        meter_source_select <= pwdata[0];
      end
      if (paddr == dso_pkg::REG_METER_GAIN &&
          pwdata[7:0] >= dso_pkg::MIN_GAIN &&
          pwdata[7:0] <= dso_pkg::MAX_GAIN) begin
        meter_gain <= pwdata[7:0];
      end
      if (paddr == dso_pkg::REG_TC_FAULT_EN) begin
        tc_fault_enable <= pwdata[0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      terminal_count_setting    <= dso_pkg::RST_TERM_COUNT;
      preliminary_count_setting <= dso_pkg::RST_PRELIM_COUNT;
    end else if (wr_en && pwdata[13:0] <= dso_pkg::MAX_COUNT) begin
      if (paddr == dso_pkg::REG_TERM_COUNT) begin
        terminal_count_setting <= pwdata[13:0];
      end
      if (paddr == dso_pkg::REG_PRELIM_COUNT) begin
        preliminary_count_setting <= pwdata[13:0];
      end
    end
  end

  // writing 1 to ctrl bit 0 restarts the counter and clears its flags
  assign clr_req = wr_en && paddr == dso_pkg::REG_CTRL && pwdata[0];

  ////////////////////////////////////////////////////////////////////////
  // event counter

  // a zero setting never matches, so a cleared counter stays quiet
  logic [13:0] event_count;
  logic        term_reached;
  logic        prelim_reached;

  // counter freezes at terminal count until cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_count <= 14'h0000;
    end else if (clr_req) begin
      event_count <= 14'h0000;
    end else if (count_pulse && !term_reached &&
                 event_count < dso_pkg::MAX_COUNT) begin
      event_count <= event_count + 14'h0001;
    end
  end

  // flag set wins over a clear arriving in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_reached <= 1'b0;
    end else if (event_count == terminal_count_setting &&
                 event_count != 14'h0000 && !term_reached) begin
      // only the first cycle at terminal is the event; later a clear wins
      term_reached <= 1'b1;
    end else if (clr_req) begin
      term_reached <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prelim_reached <= 1'b0;
    end else if (term_reached) begin
      prelim_reached <= 1'b0;
    end else if (event_count == preliminary_count_setting &&
                 event_count != 14'h0000 && !prelim_reached) begin
      prelim_reached <= 1'b1;
    end else if (clr_req) begin
      prelim_reached <= 1'b0;
    end
  end

  // stays until the counter is cleared: the drive treats it as a fault
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      external_fault <= 1'b0;
    end else if (term_reached && tc_fault_enable && !external_fault) begin
      external_fault <= 1'b1;
    end else if (clr_req) begin
      external_fault <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // brake control hysteresis

  // no release while a stop is pending, or the brake would chatter
  logic brake_active;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brake_active <= 1'b0;
    end else if (meas.out_freq >= brake_release_threshold &&
                 !flags.stop_cmd) begin
      brake_active <= 1'b1;
    end else if (flags.stop_cmd &&
                 meas.out_freq <= brake_engage_threshold) begin
      brake_active <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // relay condition select

  // codes above 22 are refused at write, so default only guards
  logic next_relay_drive;

  always_comb begin
    case (dso_pkg::dso_func_e'(relay_function_code))
      dso_pkg::FN_NONE:         next_relay_drive = 1'b0;
      dso_pkg::FN_OPERATIONAL:
        next_relay_drive = flags.ready | flags.run_cmd;
      dso_pkg::FN_MASTER_FREQ:
        next_relay_drive = meas.out_freq == meas.set_freq;
      dso_pkg::FN_ZERO_SPEED:
        next_relay_drive = meas.cmd_freq < meas.min_freq;
      dso_pkg::FN_OVER_TORQUE:  next_relay_drive = flags.over_torque;
      dso_pkg::FN_BASEBLOCK:
        next_relay_drive = flags.output_inhibit;
      dso_pkg::FN_UNDERVOLTAGE:
        next_relay_drive = flags.undervoltage_flag;
      dso_pkg::FN_TERMINAL_OP:
        next_relay_drive = flags.terminal_source;
      dso_pkg::FN_FAULT:
        next_relay_drive = flags.fault_any | external_fault;
      dso_pkg::FN_TARGET_FREQ:
        next_relay_drive = meas.out_freq == target_frequency_setting;
      dso_pkg::FN_TERM_COUNT:   next_relay_drive = term_reached;
      dso_pkg::FN_PRELIM_COUNT: next_relay_drive = prelim_reached;
      dso_pkg::FN_OV_STALL:     next_relay_drive = flags.ov_stall;
      dso_pkg::FN_OC_STALL:     next_relay_drive = flags.oc_stall;
      dso_pkg::FN_HEATSINK:
        next_relay_drive = flags.heatsink_warn;
      dso_pkg::FN_DC_BUS_HIGH:  next_relay_drive = flags.dc_bus_high;
      dso_pkg::FN_FEEDBACK_BAD:
        next_relay_drive = flags.feedback_bad;
      dso_pkg::FN_FORWARD:
        next_relay_drive = flags.forward_direction;
      dso_pkg::FN_REVERSE:
        next_relay_drive = flags.reverse_direction;
      dso_pkg::FN_STANDBY:      next_relay_drive = flags.standby;
      dso_pkg::FN_COMM_WARN:    next_relay_drive = flags.comm_warn;
      dso_pkg::FN_BRAKE:        next_relay_drive = brake_active;
      dso_pkg::FN_READY:        next_relay_drive = flags.ready;
      default:                  next_relay_drive = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay_drive <= 1'b0;
    end else begin
      relay_drive <= next_relay_drive;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // analog meter scaling
  // full scale = max frequency, or 250 % current; gain trades range
  // for resolution and the result saturates rather than wrapping

  logic [31:0] meter_num;
  logic [31:0] meter_den;
  logic [47:0] meter_scaled;
  logic [31:0] meter_full;

  always_comb begin
    meter_full = (32'h1 << METER_W) - 32'h1;
    if (meter_source_select) begin
      // current in 0.1 % units: 250 % is 2500
      meter_num = 32'(meas.out_current) * 32'(meter_gain) *
                  32'(dso_pkg::CUR_FS_DEN);
      meter_den = 32'(dso_pkg::CUR_FS_NUM) * 32'h3E8 *
                  32'(dso_pkg::GAIN_UNITY);
    end else begin
      meter_num = 32'(meas.out_freq) * 32'(meter_gain);
      meter_den = (meas.max_freq == 16'h0000) ? 32'h1 :
                  32'(meas.max_freq) * 32'(dso_pkg::GAIN_UNITY);
    end
    // numerator stays below 2^28, so the product needs 44 bits; the
    // divider is the costly part and runs every cycle on live inputs
    meter_scaled = (48'(meter_num[27:0]) * 48'(meter_full[15:0])) /
                   48'(meter_den);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_meter_output <= '0;
    end else if (meter_scaled > meter_full) begin
      analog_meter_output <= meter_full[METER_W-1:0];
    end else begin
      analog_meter_output <= meter_scaled[METER_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb read path, zero wait states

  logic [31:0] rd_mux;

  always_comb begin
    case (paddr)
      dso_pkg::REG_RELAY_FUNC:   rd_mux = {27'h0, relay_function_code};
      dso_pkg::REG_TARGET_FREQ:  rd_mux = {16'h0, target_frequency_setting};
      dso_pkg::REG_METER_SRC:    rd_mux = {31'h0, meter_source_select};
      dso_pkg::REG_METER_GAIN:   rd_mux = {24'h0, meter_gain};
      dso_pkg::REG_TERM_COUNT:   rd_mux = {18'h0, terminal_count_setting};
      dso_pkg::REG_PRELIM_COUNT: rd_mux = {18'h0, preliminary_count_setting};
      dso_pkg::REG_TC_FAULT_EN:  rd_mux = {31'h0, tc_fault_enable};
      dso_pkg::REG_BRAKE_REL:    rd_mux = {16'h0, brake_release_threshold};
      dso_pkg::REG_BRAKE_ENG:    rd_mux = {16'h0, brake_engage_threshold};
      dso_pkg::REG_STATUS:
        rd_mux = {27'h0, external_fault, brake_active, prelim_reached,
                  term_reached, relay_drive};
      dso_pkg::REG_COUNT:        rd_mux = {18'h0, event_count};
      default:                   rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // ready and error are registered so outputs come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_known(paddr);
    end
  end

endmodule // dso_selector

// ---- test/dso_load_model.sv ----
// dso_load_model: relay contact set and panel meter on the drive outputs
// assumes relay_drive high energises the coil; meter full scale is 10 V.
`timescale 1ns/1ns
module dso_load_model #(
  parameter int METER_W = 12
) (
  input  wire logic               relay_drive,
  input  wire logic [METER_W-1:0] analog_meter_output,
  output logic                    relay_normally_open_contact,
  output logic                    relay_normally_closed_contact,
  output logic [31:0]             meter_millivolts
);
  // contact bounce is not modelled; contacts follow the coil at once
  assign relay_normally_open_contact   = relay_drive;
  assign relay_normally_closed_contact = !relay_drive;
  assign meter_millivolts = (32'(analog_meter_output) * 32'h2710) /
                            ((32'h1 << METER_W) - 32'h1);
endmodule // dso_load_model

// ---- test/dso_selector_asserts.sv ----
// dso_selector_asserts: port-level checker for the status output selector
// assumes it is bound to dso_selector and sees only that module's ports.
`timescale 1ns/1ns
module dso_selector_asserts #(
  parameter int METER_W = 12
) (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire dso_pkg::dso_flags_s flags,
  input wire dso_pkg::dso_meas_s  meas,
  input wire logic                count_pulse,
  input wire logic                relay_drive,
  input wire logic                external_fault,
  input wire logic [METER_W-1:0]  analog_meter_output
);
  logic [4:0] code_q;
  logic       acc_wr;
  logic       clr_wr;

  assign acc_wr = psel && penable && pready && pwrite && !pslverr;
  assign clr_wr = acc_wr && paddr == dso_pkg::REG_CTRL && pwdata[0];

  // shadow of the relay code, so the checker needs no internal probes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_q <= dso_pkg::RST_RELAY_FUNC;
    end else if (acc_wr && paddr == dso_pkg::REG_RELAY_FUNC &&
                 pwdata[31:5] == 27'h0 &&
                 pwdata[4:0] <= dso_pkg::MAX_RELAY_FUNC) begin
      code_q <= pwdata[4:0];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////
  property p_off;
    code_q == 5'h00 |=> !relay_drive;
  endproperty
  a_off: assert property (p_off) else $error("relay on with code 0");
  property p_oper;
    code_q == 5'h01 |=> relay_drive == $past(flags.ready || flags.run_cmd);
  endproperty
  a_oper: assert property (p_oper) else $error("code 1 wrong");
  property p_rdy;
    code_q == 5'h16 |=> relay_drive == $past(flags.ready);
  endproperty
  a_rdy: assert property (p_rdy) else $error("code 22 wrong");
  property p_master;
    code_q == 5'h02 |=> relay_drive == $past(meas.out_freq == meas.set_freq);
  endproperty
  a_master: assert property (p_master) else $error("code 2 wrong");
  property p_zero;
    code_q == 5'h03 |=> relay_drive == $past(meas.cmd_freq < meas.min_freq);
  endproperty
  a_zero: assert property (p_zero) else $error("code 3 wrong");
  property p_torque;
    code_q == 5'h04 |=> relay_drive == $past(flags.over_torque);
  endproperty
  a_torque: assert property (p_torque) else $error("code 4 wrong");
  property p_fault;
    code_q == 5'h08 |=> relay_drive == $past(flags.fault_any || external_fault);
  endproperty
  a_fault: assert property (p_fault) else $error("code 8 wrong");
  property p_dir;
    code_q == 5'h11 |=> relay_drive == $past(flags.forward_direction);
  endproperty
  a_dir: assert property (p_dir) else $error("code 17 wrong");
  property p_extf;
    external_fault && !clr_wr |=> external_fault;
  endproperty
  a_extf: assert property (p_extf) else $error("fault not sticky");
  property p_pready;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_pready: assert property (p_pready) else $error("pready timing wrong");
endmodule // dso_selector_asserts

bind dso_selector dso_selector_asserts #(.METER_W(METER_W)) u_asserts (.*);

// ---- test/dso_selector_bench.sv ----
// dso_selector_bench: register-level tests of the status output selector
// assumes the design answers apb with no wait states; 100 MHz clock.
`timescale 1ns/1ns
module dso_selector_bench;
  localparam int MW = 12;
  localparam int CODES [16] = '{1,4,5,6,7,8,12,13,14,15,16,17,18,19,20,22};
  localparam int BITS  [16] = '{15,13,12,11,10,9,8,7,6,5,4,3,2,1,0,16};
  logic                pclk = 1'b0;
  logic                presetn = 1'b0;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [7:0]          paddr = 8'h00;
  logic [31:0]         pwdata = 32'h0;
  logic                count_pulse = 1'b0;
  dso_pkg::dso_flags_s flags = '0;
  dso_pkg::dso_meas_s  meas = '0;
  wire  [31:0]         prdata;
  wire                 pready;
  wire                 pslverr;
  wire                 relay_drive;
  wire                 external_fault;
  wire  [MW-1:0]       meter;
  wire                 no_closed;
  wire                 nc_closed;
  wire  [31:0]         meter_mv;
  logic [31:0]         rdat;
  logic                rerr;
  int                  error_cnt = 0;
  int                  n_checks = 0;

  always #5 pclk = ~pclk;

  dso_selector #(.METER_W(MW)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flags(flags), .meas(meas), .count_pulse(count_pulse),
    .relay_drive(relay_drive), .external_fault(external_fault),
    .analog_meter_output(meter));
  dso_load_model #(.METER_W(MW)) load (.relay_drive(relay_drive),
    .analog_meter_output(meter), .relay_normally_open_contact(no_closed),
    .relay_normally_closed_contact(nc_closed), .meter_millivolts(meter_mv));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic results;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // one apb transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) error_cnt++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check("read data", rdat, exp);
  endtask

  task automatic relay(input logic exp);
    tick(3);
    check("relay_drive", relay_drive, exp);
  endtask

  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge pclk) count_pulse <= 1'b1;
      @(posedge pclk) count_pulse <= 1'b0;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    error_cnt++;
    results();
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(dso_pkg::REG_RELAY_FUNC, 32'h8);
    rd(dso_pkg::REG_METER_SRC, 32'h0);
    rd(dso_pkg::REG_METER_GAIN, 32'h64);
    rd(dso_pkg::REG_TERM_COUNT, 32'h0);
    rd(8'h3C, 32'h0);
    check("pslverr", rerr, 1'b1);
    @(posedge pclk) flags.fault_any <= 1'b1;
    relay(1'b1);
    wr(dso_pkg::REG_RELAY_FUNC, 32'h17);
    rd(dso_pkg::REG_RELAY_FUNC, 32'h8);
    wr(dso_pkg::REG_RELAY_FUNC, 32'h0);
    @(posedge pclk) flags <= '1;
    relay(1'b0);
    check("closed contact", nc_closed, 1'b1);
    check("open contact", no_closed, 1'b0);
    foreach (CODES[i]) begin
      @(posedge pclk) flags <= '0;
      wr(dso_pkg::REG_RELAY_FUNC, CODES[i]);
      relay(1'b0);
      @(posedge pclk) flags <= dso_pkg::dso_flags_s'(17'h1 << BITS[i]);
      relay(1'b1);
    end
    @(posedge pclk) flags <= '0;
    wr(dso_pkg::REG_RELAY_FUNC, 32'h2);
    @(posedge pclk) meas.set_freq <= 16'h0BB8;
    relay(1'b0);
    @(posedge pclk) meas.out_freq <= 16'h0BB8;
    relay(1'b1);
    wr(dso_pkg::REG_RELAY_FUNC, 32'h3);
    @(posedge pclk) meas.min_freq <= 16'h01F4;
    @(posedge pclk) meas.cmd_freq <= 16'h01F3;
    relay(1'b1);
    @(posedge pclk) meas.cmd_freq <= 16'h01F4;
    relay(1'b0);
    wr(dso_pkg::REG_TARGET_FREQ, 32'h3039);
    wr(dso_pkg::REG_TARGET_FREQ, 32'hEA61);
    rd(dso_pkg::REG_TARGET_FREQ, 32'h3039);
    wr(dso_pkg::REG_RELAY_FUNC, 32'h9);
    @(posedge pclk) meas.out_freq <= 16'h3039;
    relay(1'b1);
    @(posedge pclk) meas.out_freq <= 16'h303A;
    relay(1'b0);
    wr(dso_pkg::REG_BRAKE_REL, 32'h3E8);
    wr(dso_pkg::REG_BRAKE_ENG, 32'h1F4);
    wr(dso_pkg::REG_RELAY_FUNC, 32'h15);
    @(posedge pclk) meas.out_freq <= 16'h03E8;
    relay(1'b1);
    @(posedge pclk) flags.stop_cmd <= 1'b1;
    @(posedge pclk) meas.out_freq <= 16'h0258;
    relay(1'b1);
    @(posedge pclk) meas.out_freq <= 16'h01F4;
    relay(1'b0);
    @(posedge pclk) flags.stop_cmd <= 1'b0;
    relay(1'b0);
    @(posedge pclk) meas.out_freq <= 16'h03E8;
    relay(1'b1);
    wr(dso_pkg::REG_METER_GAIN, 32'hC9);
    wr(dso_pkg::REG_METER_GAIN, 32'hC8);
    rd(dso_pkg::REG_METER_GAIN, 32'hC8);
    @(posedge pclk) meas.max_freq <= 16'hEA60;
    @(posedge pclk) meas.out_freq <= 16'h7530;
    tick(3);
    check("meter", meter, 12'hFFF);
    check("meter volts", meter_mv, 32'h2710);
    wr(dso_pkg::REG_METER_SRC, 32'h1);
    tick(3);
    check("meter", meter, 12'h000);
    @(posedge pclk) meas.out_current <= 16'h04E2;
    tick(3);
    check("meter", meter, 12'hFFF);
    wr(dso_pkg::REG_TERM_COUNT, 32'h5);
    wr(dso_pkg::REG_PRELIM_COUNT, 32'h3);
    wr(dso_pkg::REG_TC_FAULT_EN, 32'h1);
    wr(dso_pkg::REG_RELAY_FUNC, 32'hB);
    pulse(3);
    relay(1'b1);
    wr(dso_pkg::REG_RELAY_FUNC, 32'hA);
    pulse(1);
    relay(1'b0);
    pulse(1);
    tick(2);
    relay(1'b1);
    check("external_fault", external_fault, 1'b1);
    apb(1'b0, dso_pkg::REG_STATUS, 32'h0);
    check("status", rdat & 32'h16, 32'h12);
    pulse(2);
    rd(dso_pkg::REG_COUNT, 32'h5);
    wr(dso_pkg::REG_RELAY_FUNC, 32'h8);
    @(posedge pclk) flags <= '0;
    relay(1'b1);
    wr(dso_pkg::REG_CTRL, 32'h1);
    tick(2);
    check("external_fault", external_fault, 1'b0);
    rd(dso_pkg::REG_COUNT, 32'h0);
    results();
  end
endmodule // dso_selector_bench
